// ==== src/eac_byte_store.sv ====
// byte array of the data eeprom with a registered read port
`timescale 1ns/1ps
module eac_byte_store
  import eac_pkg::*;
(
  // clock
  input  wire logic                    clk_in,
  // write port
  input  wire logic                    wr_en_in,
  input  wire logic [EAC_IDX_BITS-1:0] waddr_in,
  input  wire logic [7:0]              wdata_in,
  // read port
  input  wire logic [EAC_IDX_BITS-1:0] raddr_in,
  output logic      [7:0]              rdata_out
);

  logic [7:0] cells [0:(1<<EAC_IDX_BITS)-1];

  // cells keep content across resets, as the array would
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      cells[waddr_in] <= wdata_in;
    end
  end

  // read data always from a flop
  always_ff @(posedge clk_in) begin
    rdata_out <= cells[raddr_in];
  end

endmodule : eac_byte_store

// ==== src/eac_ctrl.sv ====
// eeprom access controller: i/o registers, arming, timing and stalls
`timescale 1ns/1ps
module eac_ctrl
  import eac_pkg::*;
#(
  parameter logic [EAC_TICK_W-1:0] ATOMIC_TICKS = EAC_TICK_W'(EAC_ATOMIC_TICKS),
  parameter logic [EAC_TICK_W-1:0] SPLIT_TICKS  = EAC_TICK_W'(EAC_SPLIT_TICKS)
)
(
  // clock and resets
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        por_b_in,
  // core i/o register port
  input  wire eac_io_req_t io_req_in,
  output logic      [7:0]  io_rdata_out,
  // core side status
  input  wire logic        core_status_ibit_in,
  output logic             cpu_stall_out,
  output logic             ready_irq_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]              nvm_data_byte;
  logic [EAC_IDX_BITS-1:0] nvm_byte_index;
  logic                    ready_irq_enable;
  logic [2:0]              arm_cnt;
  logic [2:0]              stall_cnt;
  logic                    rd_pend;
  logic [1:0]              rst_sync;
  eac_mode_t               prog_action_select;
  eac_state_t              state;
  logic [EAC_TICK_W-1:0]   tick_left;
  logic [2:0]              div_cnt;
  logic                    osc_tick;
  logic [EAC_IDX_BITS-1:0] prog_idx;
  logic [7:0]              prog_data;
  logic [7:0]              mem_rdata;
  logic [7:0]              next_cell;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic ctrl_wr, data_wr, lo_wr, hi_wr, busy, master_prog_arm;
  logic go_start, rd_start, done;

  assign ctrl_wr         = io_req_in.wr && io_req_in.addr == EAC_OFS_CONTROL;
  assign data_wr         = io_req_in.wr && io_req_in.addr == EAC_OFS_DATA;
  assign lo_wr           = io_req_in.wr && io_req_in.addr == EAC_OFS_IDX_LO;
  assign hi_wr           = io_req_in.wr && io_req_in.addr == EAC_OFS_IDX_HI;
  assign busy            = state == EAC_ST_PROG;
  assign master_prog_arm = arm_cnt != 3'h0;
  assign go_start = ctrl_wr && io_req_in.wdata[EAC_BIT_GO] && master_prog_arm && !busy
                    && prog_action_select != EAC_MODE_RSVD;
  assign rd_start = ctrl_wr && io_req_in.wdata[EAC_BIT_READ] && !busy;
  assign done     = busy && osc_tick && tick_left == '0;

  // ----------------------------------------------------------------
  // system reset seen as a level in the clock domain
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // core-facing registers
  // ----------------------------------------------------------------
  // index has no reset value
  always_ff @(posedge clk_in) begin
    if (lo_wr && !busy) begin
      nvm_byte_index[7:0] <= io_req_in.wdata;
    end
    // only bit 0 of the high register stored
    if (hi_wr && !busy) begin
      nvm_byte_index[8] <= io_req_in.wdata[0];
    end
  end

  // data register: software writes, read strobe loads
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      nvm_data_byte <= EAC_DATA_RST;
      rd_pend       <= 1'b0;
    end else begin
      rd_pend <= rd_start;
      // fetched byte lands two cycles after the strobe, on the edge after rd_pend
      if (rd_pend) begin
        nvm_data_byte <= mem_rdata;
      end else if (data_wr) begin
        nvm_data_byte <= io_req_in.wdata;
      end
    end
  end

  // ready enable and arming window
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ready_irq_enable <= 1'b0;
      arm_cnt          <= 3'h0;
    end else begin
      if (ctrl_wr) begin
        ready_irq_enable <= io_req_in.wdata[EAC_BIT_RIE];
      end
      // arm window of four cycles, then self clear
      if (ctrl_wr && io_req_in.wdata[EAC_BIT_ARM]) begin
        arm_cnt <= EAC_ARM_CYCLES;
      end else if (master_prog_arm) begin
        arm_cnt <= arm_cnt - 3'h1;
      end
    end
  end

  // core stall counter; a new strobe simply reloads it
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stall_cnt <= 3'h0;
    end else if (rd_start) begin
      stall_cnt <= EAC_READ_STALL;
    end else if (go_start) begin
      stall_cnt <= EAC_GO_STALL;
    end else if (stall_cnt != 3'h0) begin
      stall_cnt <= stall_cnt - 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // programming engine; system reset only clears the mode and only when idle, so a write
  // in flight survives a system reset
  // ----------------------------------------------------------------
  // oscillator tick derived from the system clock
  always_ff @(posedge clk_in or negedge por_b_in) begin
    if (!por_b_in) begin
      div_cnt  <= 3'h0;
      osc_tick <= 1'b0;
    end else begin
      osc_tick <= div_cnt == 3'(EAC_OSC_DIV - 1);
      div_cnt  <= (div_cnt == 3'(EAC_OSC_DIV - 1)) ? 3'h0 : div_cnt + 3'h1;
    end
  end

  // mode cleared during reset only when idle
  always_ff @(posedge clk_in or negedge por_b_in) begin
    if (!por_b_in) begin
      prog_action_select <= EAC_MODE_ATOMIC;
    end else if (!rst_sync[1] && !busy) begin
      prog_action_select <= EAC_MODE_ATOMIC;
    end else if (ctrl_wr && !busy) begin
      prog_action_select <= eac_mode_t'(io_req_in.wdata[EAC_BIT_MODE +: 2]);
    end
  end

  always_ff @(posedge clk_in or negedge por_b_in) begin
    if (!por_b_in) begin
      state     <= EAC_ST_IDLE;
      tick_left <= '0;
      prog_idx  <= '0;
      prog_data <= EAC_DATA_RST;
    end else begin
      unique case (state)
        EAC_ST_IDLE: begin
          if (go_start) begin
            state     <= EAC_ST_PROG;
            prog_idx  <= nvm_byte_index;
            prog_data <= nvm_data_byte;
            tick_left <= (prog_action_select == EAC_MODE_ATOMIC) ? ATOMIC_TICKS - 1'b1
                                                                  : SPLIT_TICKS - 1'b1;
          end
        end
        EAC_ST_PROG: begin
          if (done) begin
            state <= EAC_ST_IDLE;
          end else if (osc_tick) begin
            tick_left <= tick_left - 1'b1;
          end
        end
      endcase
    end
  end

  // value left in the cell; write-only can only clear bits
  always_comb begin
    unique case (prog_action_select)
      EAC_MODE_ERASE: next_cell = EAC_ERASED;
      EAC_MODE_WRITE: next_cell = mem_rdata & prog_data;
      default:        next_cell = prog_data;
    endcase
  end

  // array indexed by the nine-bit byte index
  eac_byte_store u_store (
    .clk_in    (clk_in),
    .wr_en_in  (done),
    .waddr_in  (prog_idx),
    .wdata_in  (next_cell),
    .raddr_in  (busy ? prog_idx : nvm_byte_index),
    .rdata_out (mem_rdata)
  );

  // ----------------------------------------------------------------
  // read-back and core outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      io_rdata_out <= 8'h00;
    end else if (io_req_in.rd) begin
      unique case (io_req_in.addr)
        EAC_OFS_CONTROL: io_rdata_out <= {EAC_CTRL_UNUSED, prog_action_select,
                                          ready_irq_enable, master_prog_arm, busy, 1'b0};
        EAC_OFS_DATA:    io_rdata_out <= nvm_data_byte;
        EAC_OFS_IDX_LO:  io_rdata_out <= nvm_byte_index[7:0];
        EAC_OFS_IDX_HI:  io_rdata_out <= {EAC_HI_UNUSED, nvm_byte_index[8]};
        default:         io_rdata_out <= 8'h00;
      endcase
    end
  end

  assign cpu_stall_out = stall_cnt != 3'h0;
  assign ready_irq_out = !busy && ready_irq_enable && core_status_ibit_in;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_arm_counts_down: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    master_prog_arm && !(ctrl_wr && io_req_in.wdata[EAC_BIT_ARM])
    |=> arm_cnt == $past(arm_cnt) - 3'h1) else $error("arm window not counting");
  a_arm_lasts_four: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ctrl_wr && io_req_in.wdata[EAC_BIT_ARM] ##1 !(ctrl_wr && io_req_in.wdata[EAC_BIT_ARM])[*4]
    |=> !master_prog_arm) else $error("arm bit outlived four cycles");
  a_go_needs_arm: assert property (@(posedge clk_in) disable iff (!por_b_in)
    $rose(busy) |-> $past(master_prog_arm)) else $error("programming started unarmed");
  a_go_stall_two: assert property (@(posedge clk_in)
    disable iff (!rst_b_in || !por_b_in)
    go_start |=> cpu_stall_out [*2] ##1 !cpu_stall_out) else $error("go stall wrong");
  a_read_stall_four: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    rd_start |=> cpu_stall_out [*4] ##1 !cpu_stall_out)
    else $error("read stall not four cycles");
  a_read_loads_data: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    rd_start |=> ##1 nvm_data_byte == $past(mem_rdata)) else $error("read data not loaded");
  a_busy_blocks_read: assert property (@(posedge clk_in)
    disable iff (!rst_b_in || !por_b_in)
    busy && ctrl_wr |=> !rd_pend) else $error("read taken while busy");
  a_index_frozen: assert property (@(posedge clk_in) disable iff (!por_b_in)
    busy |=> $stable(nvm_byte_index)) else $error("index changed while busy");
  a_mode_locked: assert property (@(posedge clk_in) disable iff (!por_b_in)
    busy |=> $stable(prog_action_select)) else $error("mode changed while busy");
  a_irq_off_busy: assert property (@(posedge clk_in) disable iff (!por_b_in)
    busy |-> !ready_irq_out) else $error("ready interrupt while busy");
  a_high_reads_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    io_req_in.rd && io_req_in.addr == EAC_OFS_IDX_HI |=> io_rdata_out[7:1] == 7'h00)
    else $error("high index unused bits not zero");
  a_done_clears_go: assert property (@(posedge clk_in) disable iff (!por_b_in)
    done |=> !busy && !$past(busy, 2) == 1'b0) else $error("go bit not cleared at end");

  c_atomic_prog: cover property (@(posedge clk_in) disable iff (!por_b_in)
    go_start && prog_action_select == EAC_MODE_ATOMIC);
  c_erase_done: cover property (@(posedge clk_in) disable iff (!por_b_in)
    done && prog_action_select == EAC_MODE_ERASE);
  c_read_strobe: cover property (@(posedge clk_in) disable iff (!rst_b_in) rd_start);
  c_go_unarmed: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    ctrl_wr && io_req_in.wdata[EAC_BIT_GO] && !master_prog_arm);

endmodule : eac_ctrl

// ==== src/eac_pkg.sv ====
// constants, types and register map of the eeprom access controller
package eac_pkg;

  // ----------------------------------------------------------------
  // register offsets in the core's i/o space
  // ----------------------------------------------------------------
  localparam logic [5:0] EAC_OFS_CONTROL = 6'h1c;
  localparam logic [5:0] EAC_OFS_DATA    = 6'h1d;
  localparam logic [5:0] EAC_OFS_IDX_LO  = 6'h1e;
  localparam logic [5:0] EAC_OFS_IDX_HI  = 6'h1f;

  // ----------------------------------------------------------------
  // control register field positions and byte index width
  // ----------------------------------------------------------------
  localparam int EAC_BIT_READ = 0;
  localparam int EAC_BIT_GO   = 1;
  localparam int EAC_BIT_ARM  = 2;
  localparam int EAC_BIT_RIE  = 3;
  localparam int EAC_BIT_MODE = 4;
  localparam int EAC_IDX_BITS = 9;

  // ----------------------------------------------------------------
  // reset values and fixed patterns
  // ----------------------------------------------------------------
  localparam logic [7:0] EAC_DATA_RST   = 8'h00;
  localparam logic [7:0] EAC_ERASED     = 8'hff;
  localparam logic [6:0] EAC_HI_UNUSED  = 7'h00;
  localparam logic [1:0] EAC_CTRL_UNUSED = 2'h0;

  // ----------------------------------------------------------------
  // cycle figures seen by the core
  // ----------------------------------------------------------------
  localparam logic [2:0] EAC_ARM_CYCLES  = 3'h4;
  localparam logic [2:0] EAC_READ_STALL  = 3'h4;
  localparam logic [2:0] EAC_GO_STALL    = 3'h2;

  // ----------------------------------------------------------------
  // programming times, timed by the calibrated oscillator
  // ----------------------------------------------------------------
  localparam int EAC_CLK_KHZ      = 40000;
  localparam int EAC_OSC_KHZ      = 8000;
  localparam int EAC_ATOMIC_US    = 3400;
  localparam int EAC_SPLIT_US     = 1800;
  localparam int EAC_OSC_DIV      = EAC_CLK_KHZ / EAC_OSC_KHZ;
  localparam int EAC_ATOMIC_TICKS = EAC_ATOMIC_US * EAC_OSC_KHZ / 1000;
  localparam int EAC_SPLIT_TICKS  = EAC_SPLIT_US * EAC_OSC_KHZ / 1000;
  localparam int EAC_TICK_W       = 16;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EAC_MODE_ATOMIC = 2'b00,
    EAC_MODE_ERASE  = 2'b01,
    EAC_MODE_WRITE  = 2'b10,
    EAC_MODE_RSVD   = 2'b11
  } eac_mode_t;

  typedef enum logic {
    EAC_ST_IDLE = 1'b0,
    EAC_ST_PROG = 1'b1
  } eac_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } eac_io_req_t;

endpackage : eac_pkg

// ==== tb/eac_core_model.sv ====
// core model driving the i/o register port of the controller
`timescale 1ns/1ps
module eac_core_model
  import eac_pkg::*;
(
  // clock and stall
  input  wire logic       clk_in,
  input  wire logic       stall_in,
  // i/o register port
  output eac_io_req_t     io_req_out,
  input  wire logic [7:0] io_rdata_in
);
  initial io_req_out = '0;

  // ----
  // bus cycle
  // ----
  // a halted core issues nothing for up to 16 cycles; a request stands one cycle
  task automatic io_op(input logic wr, input logic [5:0] a, input logic [7:0] d,
                       output logic [7:0] q);
    int n;
    n = 0;
    @(negedge clk_in);
    while (stall_in === 1'b1 && n < 16) begin
      n++;
      @(negedge clk_in);
    end
    io_req_out <= '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(negedge clk_in);
    q = io_rdata_in;
    // released address and data lines show the inverse, never the old value
    io_req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : io_op
endmodule : eac_core_model

// ==== tb/eac_ctrl_tb.sv ====
// self-checking bench of the eeprom access controller
`timescale 1ns/1ps
module eac_ctrl_tb
  import eac_pkg::*;
;
  localparam int AT = 8;
  localparam int SP = 4;
  logic        clk_in = 1'b0;
  logic        rst_b_in;
  logic        por_b_in;
  logic        ibit;
  logic        rie;
  logic        stall;
  logic        irq;
  logic [7:0]  rdata;
  logic [7:0]  q;
  logic [31:0] lfsr;
  logic [8:0]  idx_tab [3];
  eac_io_req_t req;
  int          error_cnt = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          tgo;
  int          mem [512];

  always #12.5 clk_in = ~clk_in;

  eac_ctrl #(.ATOMIC_TICKS(16'h0008), .SPLIT_TICKS(16'h0004)) i_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .por_b_in(por_b_in), .io_req_in(req),
    .io_rdata_out(rdata), .core_status_ibit_in(ibit), .cpu_stall_out(stall),
    .ready_irq_out(irq));
  eac_core_model i_core (.clk_in(clk_in), .stall_in(stall), .io_req_out(req),
    .io_rdata_in(rdata));

  // ----
  // helpers
  // ----
  task automatic final_report();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // hang guard, run needs several hundred cycles
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      error_cnt++;
      final_report();
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // bit 7 always written zero
  function automatic logic [7:0] ctl(input logic [1:0] m, input logic [2:0] s);
    return {2'b00, m, rie, s};
  endfunction : ctl

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] x;
    i_core.io_op(1'b1, a, d, x);
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    i_core.io_op(1'b0, a, 8'h00, v);
  endtask : rd

  task automatic chk_stall(input logic [7:0] n);
    logic [7:0] c;
    c = 8'h00;
    while (stall === 1'b1 && c < 8'h10) begin
      c++;
      @(negedge clk_in);
    end
    chk("stall_len", n, c);
  endtask : chk_stall

  task automatic set_idx(input logic [8:0] ix);
    wr(EAC_OFS_IDX_HI, {EAC_HI_UNUSED, ix[8]});
    wr(EAC_OFS_IDX_LO, ix[7:0]);
  endtask : set_idx

  task automatic rdbyte(input logic [8:0] ix);
    logic [7:0] v;
    set_idx(ix);
    wr(EAC_OFS_CONTROL, ctl(2'b00, 3'b001));
    chk_stall(8'h04);
    rd(EAC_OFS_DATA, v);
    chk("read_byte", 8'(mem[ix]), v);
  endtask : rdbyte

  task automatic prog_start(input logic [1:0] m, input logic [8:0] ix, input logic [7:0] d);
    logic [7:0] v;
    set_idx(ix);
    wr(EAC_OFS_DATA, d);
    wr(EAC_OFS_CONTROL, ctl(m, 3'b100));
    wr(EAC_OFS_CONTROL, ctl(m, 3'b110));
    tgo = cyc;
    chk_stall(8'h02);
    chk("irq_busy", 8'h00, {7'h00, irq});
    // long atomic run leaves room to poke the locked registers
    if (m == EAC_MODE_ATOMIC) begin
      wr(EAC_OFS_CONTROL, ctl(2'b01, 3'b000));
      wr(EAC_OFS_IDX_LO, ~ix[7:0]);
      wr(EAC_OFS_CONTROL, ctl(2'b01, 3'b001));
      rd(EAC_OFS_CONTROL, v);
      chk("mode_held", ctl(m, 3'b010), v);
      rd(EAC_OFS_DATA, v);
      chk("data_held", d, v);
    end
    case (m)
      2'b00:   mem[ix] = d;
      2'b01:   mem[ix] = 255;
      default: mem[ix] = mem[ix] & d;
    endcase
  endtask : prog_start

  task automatic prog_end(input int t);
    logic [7:0] v;
    int dur;
    v = 8'h02;
    while (v[1] === 1'b1 && cyc - tgo < 300) begin
      rd(EAC_OFS_CONTROL, v);
    end
    dur = cyc - tgo;
    check_count++;
    if (dur < (t - 1) * EAC_OSC_DIV || dur > t * EAC_OSC_DIV + 8) begin
      error_cnt++;
      $display("unexpected busy_cycles expected %0d seen %0d", t * EAC_OSC_DIV, dur);
    end
    chk("irq_ready", {7'h00, rie & ibit}, {7'h00, irq});
  endtask : prog_end

  task automatic prog(input logic [1:0] m, input logic [8:0] ix, input logic [7:0] d);
    prog_start(m, ix, d);
    prog_end((m == 2'b00) ? AT : SP);
  endtask : prog

  task automatic pulse_reset();
    rst_b_in = 1'b0;
    repeat (3) @(negedge clk_in);
    rst_b_in = 1'b1;
  endtask : pulse_reset

  // ----
  // main sequence
  // ----
  initial begin
    rst_b_in = 1'b0;
    por_b_in = 1'b0;
    ibit = 1'b0;
    rie = 1'b0;
    lfsr = 32'h1b0a5791;
    idx_tab = '{9'h000, 9'h1ff, lfsr[20:12]};
    repeat (8) @(negedge clk_in);
    rst_b_in = 1'b1;
    por_b_in = 1'b1;
    rd(EAC_OFS_DATA, q);
    chk("data_rst", EAC_DATA_RST, q);
    rd(EAC_OFS_CONTROL, q);
    chk("ctrl_rst", 8'h00, q);
    wr(EAC_OFS_IDX_HI, 8'hff);
    rd(EAC_OFS_IDX_HI, q);
    chk("idx_high", 8'h01, q);
    // atomic, erase, then write-only on the erased byte
    foreach (idx_tab[k]) begin
      lfsr = lfsr_next(lfsr);
      ibit = lfsr[7];
      rie = lfsr[9];
      prog(2'b00, idx_tab[k], lfsr[7:0]);
      rdbyte(idx_tab[k]);
      prog(2'b01, idx_tab[k], 8'h00);
      rdbyte(idx_tab[k]);
      prog(2'b10, idx_tab[k], lfsr[15:8]);
      rdbyte(idx_tab[k]);
    end
    // ends of the index range must not alias
    foreach (idx_tab[k]) rdbyte(idx_tab[k]);
    rie = 1'b1;
    ibit = 1'b1;
    wr(EAC_OFS_CONTROL, ctl(2'b00, 3'b000));
    chk("irq_on", 8'h01, {7'h00, irq});
    ibit = 1'b0;
    @(negedge clk_in);
    chk("irq_gate", 8'h00, {7'h00, irq});
    wr(EAC_OFS_CONTROL, ctl(2'b00, 3'b010));
    rd(EAC_OFS_CONTROL, q);
    chk("go_unarmed", ctl(2'b00, 3'b000), q);
    wr(EAC_OFS_CONTROL, ctl(2'b11, 3'b100));
    rd(EAC_OFS_CONTROL, q);
    chk("arm_set", ctl(2'b11, 3'b100), q);
    wr(EAC_OFS_CONTROL, ctl(2'b11, 3'b110));
    rd(EAC_OFS_CONTROL, q);
    chk("go_rsvd", 8'h00, {7'h00, q[1]});
    wr(EAC_OFS_CONTROL, ctl(2'b00, 3'b100));
    repeat (6) @(negedge clk_in);
    rd(EAC_OFS_CONTROL, q);
    chk("arm_clear", ctl(2'b00, 3'b000), q);
    wr(EAC_OFS_CONTROL, ctl(2'b00, 3'b010));
    rd(EAC_OFS_CONTROL, q);
    chk("go_late", ctl(2'b00, 3'b000), q);
    // reset while erasing: the erase must still finish
    rie = 1'b0;
    prog_start(2'b01, idx_tab[2], 8'h00);
    pulse_reset();
    rd(EAC_OFS_CONTROL, q);
    chk("mode_kept", ctl(2'b01, 3'b010), q);
    prog_end(SP);
    rdbyte(idx_tab[2]);
    wr(EAC_OFS_CONTROL, ctl(2'b10, 3'b000));
    pulse_reset();
    rd(EAC_OFS_CONTROL, q);
    chk("mode_clear", 8'h00, q);
    rd(EAC_OFS_DATA, q);
    chk("data_clear", EAC_DATA_RST, q);
    final_report();
  end
endmodule : eac_ctrl_tb
